// ### logic/asu_pkg.sv
// asu_pkg: constants, modes and carriers of the add/subtract unit.
// assumes a 24-bit word machine with 12-bit core addresses.
// How it works
// - plain add: L plus Y into L
// - replace: result to L and Y
// - negative results kept in two's complement
// - non-trap overflow: flag untouched, no trap
// - trap overflow: set flag, start trap
// - trap saves instruction address, 0023 bits 0-11
// - trap then resumes fetching at 0013
// - subtract: L plus complement of Y
// - long: Y low half, Y+1 high half
// - low with R, high with L, carry linked
// - long non-replace: Y and Y+1 left untouched
// - long replace: R to Y, L to Y+1
// - long: R sign copies L sign
// - long replace: stored low sign copies high
// - long overflow: carry out of L bit 22
// - long subtract: complement both, same carry linkage
// - operand address may be index-modified
package asu_pkg;

    localparam int WORD_W = 24; // data word width
    localparam int ADDR_W = 12; // core address width
    localparam int SIGN_B = 23; // sign bit position
    localparam int LONG_W = 47; // 24-bit high plus 23-bit low

    // fixed core locations for the overflow trap
    localparam logic [11:0] TRAP_SAVE_ADDR = 12'h013; // 0023 octal
    localparam logic [11:0] TRAP_NEXT_ADDR = 12'h00B; // 0013 octal

    // reset values
    localparam logic [23:0] ACC_RST = 24'h000000;
    localparam logic [11:0] ADDR_RST = 12'h000;

    // operation kinds
    typedef enum logic [1:0] {
        OP_SUM,
        OP_DIFFERENCE,
        OP_LONG_SUM,
        OP_LONG_DIFFERENCE
    } asu_op_t;

    // one instruction handed to the unit
    typedef struct packed {
        asu_op_t op; // kind of arithmetic
        logic writeback; // result also back to memory
        logic trapping; // trap on overflow
        logic [11:0] addr; // operand address field
        logic idx_en; // apply index register
        logic [11:0] idx; // index register value
        logic [11:0] pc; // location of this instruction
    } asu_cmd_t;

    // request toward core memory
    typedef struct packed {
        logic req; // held until ack
        logic we; // write when high
        logic [11:0] addr; // word address
        logic [23:0] wdata; // write data
    } asu_mem_t;

    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_LO,
        ST_RD_HI,
        ST_EXEC,
        ST_WR_LO,
        ST_WR_HI,
        ST_RD_TRAP,
        ST_WR_TRAP
    } asu_state_t;

    // whole state of the unit
    typedef struct packed {
        asu_state_t st; // sequencer
        asu_cmd_t cmd; // latched instruction
        logic [11:0] ea; // effective address
        logic [23:0] y_lo; // operand or low half
        logic [23:0] y_hi; // high half
        logic [23:0] acc_l; // left accumulator
        logic [23:0] acc_r; // right accumulator
        logic ovf_hit; // overflow of this op
        logic ovf_flag; // sticky overflow indicator
        asu_mem_t mem; // memory request
        logic done; // completion pulse
        logic trap; // trap taken, with done
        logic [11:0] next_pc; // next fetch address
    } asu_st_t;

endpackage

// ### logic/asu_core.sv
// asu_core: add/subtract datapath with memory operand sequencing.
// assumes a core memory that answers each request with one ack
// cycle, read data valid in that cycle; fetch and decode sit outside.
// assumes presets of L and R arrive through acc_wr_i while idle,
// and that the fetch logic makes the jump named by next_pc_o.
`timescale 1ns/1ps
`default_nettype none

module asu_core (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // instruction command
    // start_i is ignored while busy_o is high
    input wire logic start_i,
    input wire asu_pkg::asu_cmd_t cmd_i,
    output logic busy_o,
    // core memory
    // req, we, addr and wdata hold until mem_ack_i
    output var asu_pkg::asu_mem_t mem_o,
    input wire logic [23:0] mem_rdata_i,
    input wire logic mem_ack_i,
    // accumulator preset and view
    // acc_wr_i is honoured only while idle
    input wire logic acc_wr_i,
    input wire logic [23:0] acc_l_i,
    input wire logic [23:0] acc_r_i,
    output logic [23:0] acc_l_o,
    output logic [23:0] acc_r_o,
    // status
    // done_o and trap_o pulse for one cycle
    input wire logic ovf_clr_i,
    output logic arith_ovf_flag_o,
    output logic done_o,
    output logic trap_o,
    output logic [11:0] next_pc_o
);

    // every flop of the unit sits in st_reg: one comb process
    // fills st_next and one clocked process registers it, so no
    // field can pick up a second driver by accident
    // register and its next value
    asu_pkg::asu_st_t st_reg;
    asu_pkg::asu_st_t st_next;

    // decoded view of the latched command
    // two plain wires, kept apart for readable conditions
    logic is_long; // two-word operand
    logic is_diff; // subtract flavour

    // short arithmetic terms
    // all combinational; s_res and s_ovf feed the result select process
    logic [23:0] s_b; // second addend, maybe complemented
    logic [24:0] s_sum; // sum with carry out
    logic [23:0] s_res; // short result
    logic s_ovf; // short overflow

    // long arithmetic terms
    // the R sign bit takes no part in these
    logic [46:0] l_a; // L with R magnitude below it
    logic [46:0] l_b; // Y+1 with Y magnitude below it
    logic [47:0] l_sum; // sum with carry out
    logic [46:0] l_res; // long result
    logic l_ovf; // long overflow

    // result words as they leave the adder
    // picked by is_long below
    logic [23:0] res_l; // new left accumulator
    logic [23:0] res_r; // new right accumulator
    logic op_ovf; // overflow of the current op

    // operand width of the long form must match the words
    // the long adder packs L over R[22:0], so a package edit that
    // breaks this sum is refused at elaboration, not at run time
    if (asu_pkg::LONG_W != 2 * asu_pkg::WORD_W - 1) begin : g_long_width
        $error("long width does not fit two words");
    end

    // decoded from the latched command, never from cmd_i, which
    // may change as soon as the command has been taken
    assign is_long = (st_reg.cmd.op == asu_pkg::OP_LONG_SUM) ||
                     (st_reg.cmd.op == asu_pkg::OP_LONG_DIFFERENCE);
    assign is_diff = (st_reg.cmd.op == asu_pkg::OP_DIFFERENCE) ||
                     (st_reg.cmd.op == asu_pkg::OP_LONG_DIFFERENCE);

    // short adder: complement plus one gives the two's complement
    // the plus one rides in as a carry, so add and subtract share
    // one 24-bit adder; no separate negate stage is needed
    // overflow is judged on signs, which matches a carry into the
    // sign bit that differs from the carry out of it
    always_comb begin
        s_b = is_diff ? ~st_reg.y_lo : st_reg.y_lo;
        s_sum = {1'b0, st_reg.acc_l} + {1'b0, s_b} + {24'h000000, is_diff};
        s_res = s_sum[23:0]; // already two's complement when negative
        // like signs in, other sign out: carry went into the sign
        s_ovf = (st_reg.acc_l[23] == s_b[23]) && (s_res[23] != s_b[23]);
    end

    // long adder: one 47-bit sum, so the R carry lands in L bit 0
    // R bit 23 is only a copy of the L sign, so it is left out and
    // the R magnitude sits right under L in one wide sum
    // limitation: operand words whose signs differ add wrongly;
    // keeping them equal is the program's duty
    always_comb begin
        // R sign bit takes no part; its magnitude sits below L
        l_a = {st_reg.acc_l, st_reg.acc_r[22:0]};
        // Y is the low half, Y+1 the high half
        l_b = {st_reg.y_hi, st_reg.y_lo[22:0]};
        if (is_diff) begin
            l_b = ~l_b; // complement both halves, carry linked
        end
        l_sum = {1'b0, l_a} + {1'b0, l_b} + {47'h000000000000, is_diff};
        l_res = l_sum[46:0];
        // a mismatched sign on the two words gives garbage here
        // carry out of L bit 22 changes the sign wrongly
        l_ovf = (l_a[46] == l_b[46]) && (l_res[46] != l_b[46]);
    end

    // pick the result for the current operation
    // short forms only touch L; long forms rewrite both halves
    // and copy the L sign into R bit 23 on the way out
    always_comb begin
        if (is_long) begin
            res_l = l_res[46:23];
            // R sign made equal to L sign
            res_r = {l_res[46], l_res[22:0]};
            op_ovf = l_ovf;
        end else begin
            res_l = s_res;
            res_r = st_reg.acc_r; // short forms leave R alone
            op_ovf = s_ovf;
        end
    end

    // next-state logic of the whole unit
    // order: read Y, read Y+1 for long forms, execute, write back
    // for replace forms, then read and rewrite the save word when
    // a trapping form overflowed; each memory step holds its
    // request until the ack, so a slow memory only stretches it
    always_comb begin
        logic fin; // instruction ends this cycle
        logic take_trap; // trap sequence is due
        fin = 1'b0;
        take_trap = st_reg.cmd.trapping && st_reg.ovf_hit;
        st_next = st_reg;
        st_next.done = 1'b0; // pulses
        st_next.trap = 1'b0;

        // software clear of the sticky indicator; a set below wins
        if (ovf_clr_i) begin
            st_next.ovf_flag = 1'b0;
        end
        unique case (st_reg.st)
            asu_pkg::ST_IDLE: begin
                // a preset only while no instruction runs
                // a preset and a start on one edge both land, and
                // the command then works on the preset values
                if (acc_wr_i) begin
                    st_next.acc_l = acc_l_i;
                    st_next.acc_r = acc_r_i;
                end
                // start is ignored while busy, so no queue is needed
                if (start_i) begin
                    st_next.cmd = cmd_i;
                    st_next.ovf_hit = 1'b0;
                    // index added before any memory access
                    st_next.ea = cmd_i.idx_en ? cmd_i.addr + cmd_i.idx : cmd_i.addr;
                    st_next.mem.req = 1'b1;
                    st_next.mem.we = 1'b0;
                    st_next.mem.addr = st_next.ea;
                    st_next.st = asu_pkg::ST_RD_LO;
                end
            end

            asu_pkg::ST_RD_LO: begin
                // operand or low half arrives
                // without ack the request stands as it is
                if (mem_ack_i) begin
                    st_next.y_lo = mem_rdata_i;
                    if (is_long) begin
                        // high half from the following word
                        st_next.mem.addr = st_reg.ea + 12'h001;
                        st_next.st = asu_pkg::ST_RD_HI;
                    end else begin
                        st_next.mem.req = 1'b0;
                        st_next.st = asu_pkg::ST_EXEC;
                    end
                end
            end

            asu_pkg::ST_RD_HI: begin
                // high half arrives
                // read data is taken in the ack cycle only
                if (mem_ack_i) begin
                    st_next.y_hi = mem_rdata_i;
                    st_next.mem.req = 1'b0;
                    st_next.st = asu_pkg::ST_EXEC;
                end
            end

            asu_pkg::ST_EXEC: begin
                // accumulators always take the result
                // the flag is set here, before any write or save,
                // and a clear on this same edge loses to the set
                st_next.acc_l = res_l;
                st_next.acc_r = res_r;
                st_next.ovf_hit = op_ovf;
                // only trapping forms touch the indicator
                if (st_reg.cmd.trapping && op_ovf) begin
                    st_next.ovf_flag = 1'b1;
                end
                if (st_reg.cmd.writeback) begin
                    // trapping replace forms write first, then trap
                    // result back to the operand word
                    st_next.mem.req = 1'b1;
                    st_next.mem.we = 1'b1;
                    st_next.mem.addr = st_reg.ea;
                    // stored low sign follows the high sign
                    st_next.mem.wdata = is_long ? res_r : res_l;
                    st_next.st = asu_pkg::ST_WR_LO;
                end else if (st_reg.cmd.trapping && op_ovf) begin
                    // no write back: straight to the trap save
                    // operand words stay untouched without writeback
                    st_next.mem.req = 1'b1;
                    st_next.mem.we = 1'b0;
                    st_next.mem.addr = asu_pkg::TRAP_SAVE_ADDR;
                    st_next.st = asu_pkg::ST_RD_TRAP;
                end else begin
                    // overflow without trap just ends the op
                    fin = 1'b1;
                end
            end

            asu_pkg::ST_WR_LO: begin
                // first write accepted
                // the read data of a write ack is not used
                if (mem_ack_i) begin
                    if (is_long) begin
                        // L result to the high word
                        st_next.mem.addr = st_reg.ea + 12'h001;
                        st_next.mem.wdata = st_reg.acc_l;
                        st_next.st = asu_pkg::ST_WR_HI;
                    end else if (take_trap) begin
                        st_next.mem.we = 1'b0;
                        st_next.mem.addr = asu_pkg::TRAP_SAVE_ADDR;
                        st_next.st = asu_pkg::ST_RD_TRAP;
                    end else begin
                        st_next.mem.req = 1'b0;
                        fin = 1'b1;
                    end
                end
            end

            asu_pkg::ST_WR_HI: begin
                // high word accepted
                if (mem_ack_i) begin
                    if (take_trap) begin
                        st_next.mem.we = 1'b0;
                        st_next.mem.addr = asu_pkg::TRAP_SAVE_ADDR;
                        st_next.st = asu_pkg::ST_RD_TRAP;
                    end else begin
                        st_next.mem.req = 1'b0;
                        fin = 1'b1;
                    end
                end
            end

            asu_pkg::ST_RD_TRAP: begin
                // read first so bits 12-23 of the save word survive
                // the request stays up; only we turns on for the
                // rewrite, whose low bits name this instruction
                if (mem_ack_i) begin
                    st_next.mem.we = 1'b1;
                    st_next.mem.wdata = {mem_rdata_i[23:12], st_reg.cmd.pc};
                    st_next.st = asu_pkg::ST_WR_TRAP;
                end
            end

            asu_pkg::ST_WR_TRAP: begin
                // save word written, trap completes
                // the trap is never reported before the save lands
                if (mem_ack_i) begin
                    st_next.mem.req = 1'b0;
                    st_next.mem.we = 1'b0;
                    fin = 1'b1;
                end
            end
            // all eight codes are states, so no default branch
        endcase

        // common end of every instruction
        if (fin) begin
            st_next.done = 1'b1;
            st_next.trap = take_trap || (st_reg.st == asu_pkg::ST_EXEC &&
                                         st_reg.cmd.trapping && op_ovf);
            // otherwise the fetch just moves on to the next word
            // fetch goes to the fixed location after a trap
            st_next.next_pc = st_next.trap ? asu_pkg::TRAP_NEXT_ADDR :
                                             st_reg.cmd.pc + 12'h001;
            st_next.st = asu_pkg::ST_IDLE;
        end
    end

    // state register, synchronous reset to constants only
    // reset drops the memory request at once; an ack that still
    // arrives afterwards is ignored while the unit is idle
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_reg.st <= asu_pkg::ST_IDLE;
            st_reg.cmd <= '0;
            st_reg.ea <= asu_pkg::ADDR_RST;
            st_reg.y_lo <= asu_pkg::ACC_RST;
            st_reg.y_hi <= asu_pkg::ACC_RST;
            st_reg.acc_l <= asu_pkg::ACC_RST;
            st_reg.acc_r <= asu_pkg::ACC_RST;
            st_reg.ovf_hit <= 1'b0;
            st_reg.ovf_flag <= 1'b0;
            st_reg.mem <= '0;
            st_reg.done <= 1'b0;
            st_reg.trap <= 1'b0;
            st_reg.next_pc <= asu_pkg::ADDR_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    // done and trap are one-cycle pulses; next_pc holds until the next
    // instruction ends, the accumulators until a preset or execute step
    assign busy_o = (st_reg.st != asu_pkg::ST_IDLE);
    assign mem_o = st_reg.mem;
    assign acc_l_o = st_reg.acc_l;
    assign acc_r_o = st_reg.acc_r;
    assign arith_ovf_flag_o = st_reg.ovf_flag;
    assign done_o = st_reg.done;
    assign trap_o = st_reg.trap;
    assign next_pc_o = st_reg.next_pc;

endmodule

`default_nettype wire

// ### test/asu_core_monitor.sv
// asu_core_monitor: port-level checks of the add/subtract unit.
// assumes one clock domain, reset by rst_i, bound below onto asu_core.
`timescale 1ns/1ps
`default_nettype none

module asu_core_monitor (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // command and memory
    input wire logic start_i,
    input wire asu_pkg::asu_cmd_t cmd_i,
    input wire logic busy_o,
    input wire asu_pkg::asu_mem_t mem_o,
    input wire logic mem_ack_i,
    // results
    input wire logic [23:0] acc_l_o,
    input wire logic [23:0] acc_r_o,
    input wire logic arith_ovf_flag_o,
    input wire logic done_o,
    input wire logic trap_o,
    input wire logic [11:0] next_pc_o
);
    // command as taken, kept since cmd_i may change mid-run
    asu_pkg::asu_cmd_t cmd_reg;

    // capture at the take edge only
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cmd_reg <= '0;
        end else if (start_i && !busy_o) begin
            cmd_reg <= cmd_i;
        end
    end

    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);

    done_idle_a: assert property (done_o |-> !busy_o)
        else $error("done raised while busy");
    req_hold_a: assert property (mem_o.req && !mem_ack_i |=> mem_o.req && $stable(mem_o))
        else $error("memory request changed before ack");
    trap_cause_a: assert property (trap_o |-> done_o && arith_ovf_flag_o && cmd_reg.trapping)
        else $error("trap without trapping overflow");
    trap_pc_a: assert property (trap_o |-> next_pc_o == asu_pkg::TRAP_NEXT_ADDR)
        else $error("trap resumes at wrong place");
    plain_pc_a: assert property (done_o && !trap_o |-> next_pc_o == cmd_reg.pc + 12'h001)
        else $error("plain end not sequential");
    trap_save_a: assert property (trap_o |-> $past(mem_o.we)
        && $past(mem_o.addr) == asu_pkg::TRAP_SAVE_ADDR
        && $past(mem_o.wdata[11:0]) == cmd_reg.pc)
        else $error("trap save write wrong");
    flag_rise_a: assert property ($rose(arith_ovf_flag_o) |-> busy_o && cmd_reg.trapping)
        else $error("flag set by non-trapping op");
    long_sign_a: assert property (done_o
        && cmd_reg.op inside {asu_pkg::OP_LONG_SUM, asu_pkg::OP_LONG_DIFFERENCE}
        |-> acc_r_o[23] == acc_l_o[23])
        else $error("right sign differs from left");
    run_bound_a: assert property ($rose(busy_o) |-> ##[2:200] done_o)
        else $error("instruction never finished");

    // main scenarios reached
    cover property (trap_o);
    cover property (done_o && cmd_reg.op == asu_pkg::OP_LONG_SUM && cmd_reg.writeback);
    cover property (done_o && cmd_reg.op == asu_pkg::OP_LONG_DIFFERENCE);
endmodule

bind asu_core asu_core_monitor u_asu_core_monitor (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .start_i(start_i),
    .cmd_i(cmd_i),
    .busy_o(busy_o),
    .mem_o(mem_o),
    .mem_ack_i(mem_ack_i),
    .acc_l_o(acc_l_o),
    .acc_r_o(acc_r_o),
    .arith_ovf_flag_o(arith_ovf_flag_o),
    .done_o(done_o),
    .trap_o(trap_o),
    .next_pc_o(next_pc_o)
);

`default_nettype wire

// ### test/asu_mem_model.sv
// asu_mem_model: behavioural core memory answering the unit.
// assumes the bench preloads words through the mem array.
`timescale 1ns/1ps
`default_nettype none

module asu_mem_model (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // pacing and request
    input wire logic slow_i,
    input wire asu_pkg::asu_mem_t mem_i,
    // answer
    output logic [23:0] rdata_o,
    output logic ack_o
);
    logic [23:0] mem [0:4095]; // word store
    logic [1:0] wait_reg; // cycles spent on this request

    // one ack per request, slow mode stalls three cycles
    always @(posedge clock_i) begin
        ack_o <= 1'b0;
        rdata_o <= ~rdata_o; // stale data never looks valid
        if (rst_i) begin
            wait_reg <= 2'h0;
            rdata_o <= 24'h5A5A5A;
        end else if (mem_i.req && !ack_o) begin
            if (wait_reg == (slow_i ? 2'h3 : 2'h0)) begin
                ack_o <= 1'b1;
                wait_reg <= 2'h0;
                rdata_o <= mem[mem_i.addr];
                if (mem_i.we) begin
                    mem[mem_i.addr] <= mem_i.wdata;
                end
            end else begin
                wait_reg <= wait_reg + 2'h1;
            end
        end
    end
endmodule

`default_nettype wire

// ### test/tb.sv
// tb: self-checking bench of the add/subtract unit.
// assumes asu_core, asu_mem_model and the bound monitor.
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic clock_i, rst_i, start_i, acc_wr_i, ovf_clr_i, slow, trap_seen;
    logic mem_ack_i, busy_o, arith_ovf_flag_o, done_o, trap_o;
    logic [23:0] mem_rdata_i, acc_l_i, acc_r_i, acc_l_o, acc_r_o;
    logic [11:0] next_pc_o;
    asu_pkg::asu_cmd_t cmd_i;
    asu_pkg::asu_mem_t mem_o;
    int fail_count, compares, cycles;

    asu_core u_asu_core (.clock_i(clock_i), .rst_i(rst_i), .start_i(start_i),
        .cmd_i(cmd_i), .busy_o(busy_o), .mem_o(mem_o), .mem_rdata_i(mem_rdata_i),
        .mem_ack_i(mem_ack_i), .acc_wr_i(acc_wr_i), .acc_l_i(acc_l_i),
        .acc_r_i(acc_r_i), .acc_l_o(acc_l_o), .acc_r_o(acc_r_o),
        .ovf_clr_i(ovf_clr_i), .arith_ovf_flag_o(arith_ovf_flag_o),
        .done_o(done_o), .trap_o(trap_o), .next_pc_o(next_pc_o));
    asu_mem_model u_asu_mem_model (.clock_i(clock_i), .rst_i(rst_i), .slow_i(slow),
        .mem_i(mem_o), .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));

    // compare and count
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // closing report
    task automatic test_done();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // preset, start one instruction on word 0x120, wait for done;
    // reached as 0x100 indexed by 0x020, or direct when no flag clear
    task automatic run(input asu_pkg::asu_op_t op, input logic [2:0] f,
        input logic [23:0] l, input logic [23:0] r, input logic [23:0] lo,
        input logic [23:0] hi);
        int k;
        u_asu_mem_model.mem[12'h120] = lo;
        u_asu_mem_model.mem[12'h121] = hi;
        u_asu_mem_model.mem[12'h013] = 24'hABC000;
        @(posedge clock_i);
        acc_wr_i <= 1'b1;
        acc_l_i <= l;
        acc_r_i <= r;
        ovf_clr_i <= f[2];
        @(posedge clock_i);
        acc_wr_i <= 1'b0;
        ovf_clr_i <= 1'b0;
        start_i <= 1'b1;
        cmd_i <= '{op, f[1], f[0], f[2] ? 12'h100 : 12'h120, f[2], 12'h020, 12'h345};
        @(posedge clock_i);
        start_i <= 1'b0;
        k = 0;
        do begin
            @(negedge clock_i);
            k++;
        end while (done_o !== 1'b1 && k < 300);
        trap_seen = trap_o;
        check(done_o, 1'b1);
    endtask

    // outcome: accumulators, both words, flag, trap, next fetch, save word
    task automatic res(input logic [23:0] l, input logic [23:0] r, input logic [23:0] m0,
        input logic [23:0] m1, input logic fl, input logic tp, input logic [11:0] pc,
        input logic [23:0] sv);
        check(acc_l_o, l);
        check(acc_r_o, r);
        check(u_asu_mem_model.mem[12'h120], m0);
        check(u_asu_mem_model.mem[12'h121], m1);
        check(arith_ovf_flag_o, fl);
        check(trap_seen, tp);
        check(next_pc_o, pc);
        check(u_asu_mem_model.mem[12'h013], sv);
    endtask

    // short ops with negative results, plain and replace
    task automatic t_short();
        run(asu_pkg::OP_SUM, 3'h4, 24'h000001, 24'h0, 24'hFFFFFC, 24'h0);
        res(24'hFFFFFD, 24'h0, 24'hFFFFFC, 24'h0, 0, 0, 12'h346, 24'hABC000);
        run(asu_pkg::OP_DIFFERENCE, 3'h6, 24'h000003, 24'h0, 24'h000005, 24'h0);
        res(24'hFFFFFE, 24'h0, 24'hFFFFFE, 24'h0, 0, 0, 12'h346, 24'hABC000);
        $display("test short done");
    endtask

    // overflow in every replace/trap combination, then flag left alone
    task automatic t_ovf();
        logic [23:0] y;
        for (int i = 0; i < 4; i++) begin
            y = i[0] ? 24'h7FFFFF : 24'h800000;
            run(i[0] ? asu_pkg::OP_DIFFERENCE : asu_pkg::OP_SUM, {1'b1, i[0], i[1]},
                i[0] ? 24'h800000 : 24'h7FFFFF, 24'h0, 24'h000001, 24'h0);
            res(y, 24'h0, i[0] ? y : 24'h000001, 24'h0, i[1], i[1],
                i[1] ? 12'h00B : 12'h346, i[1] ? 24'hABC345 : 24'hABC000);
        end
        run(asu_pkg::OP_SUM, 3'h0, 24'h000001, 24'h0, 24'h000001, 24'h0);
        res(24'h000002, 24'h0, 24'h000001, 24'h0, 1, 0, 12'h346, 24'hABC000);
        $display("test overflow done");
    endtask

    // long ops against a stalling memory
    task automatic t_long();
        slow = 1'b1;
        // operand signs kept equal by the program
        run(asu_pkg::OP_LONG_SUM, 3'h4, 24'h000001, 24'h400000, 24'h400000, 24'h000002);
        res(24'h000004, 24'h0, 24'h400000, 24'h000002, 0, 0, 12'h346, 24'hABC000);
        run(asu_pkg::OP_LONG_SUM, 3'h6, 24'hFFFFFF, 24'hFFFFFF, 24'hFFFFFF, 24'hFFFFFF);
        res(24'hFFFFFF, 24'hFFFFFE, 24'hFFFFFE, 24'hFFFFFF, 0, 0, 12'h346, 24'hABC000);
        run(asu_pkg::OP_LONG_DIFFERENCE, 3'h4, 24'h0, 24'h0, 24'h000001, 24'h0);
        res(24'hFFFFFF, 24'hFFFFFF, 24'h000001, 24'h0, 0, 0, 12'h346, 24'hABC000);
        run(asu_pkg::OP_LONG_SUM, 3'h7, 24'h7FFFFF, 24'h7FFFFF, 24'h000001, 24'h0);
        res(24'h800000, 24'h800000, 24'h800000, 24'h800000, 1, 1, 12'h00B, 24'hABC345);
        $display("test long done");
    endtask

    // clock, 100 ns period
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    // hang guard, far beyond the few hundred cycles the tests need
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            test_done();
        end
    end

    // main sequence
    initial begin
        {rst_i, start_i, acc_wr_i, ovf_clr_i, slow} = 5'h10;
        {acc_l_i, acc_r_i} = '0;
        cmd_i = '0;
        {fail_count, compares, cycles} = '0;
        repeat (12) @(posedge clock_i);
        rst_i <= 1'b0;
        t_short();
        t_ovf();
        t_long();
        test_done();
    end
endmodule

`default_nettype wire
